// ### logic/acrp_device.sv
`timescale 1ns/1ns
`include "acrp_params.svh"

module acrp_device #(
    parameter int PWRUP_CYC = `ACRP_PWRUP_CYC,
    parameter int CONV_CYC  = `ACRP_CONV_CYC
) (
    input  wire logic                 sys_clk,     // 10 MHz clock
    input  wire logic                 sys_rst,     // Sync reset, high
    input  wire logic                 clk_en,      // Low freezes state
    input  wire acrp_pkg::acrp_code_t analog_code, // Input level as code
    acrp_if.dev                       link,        // Host-facing pins
    output logic                      powered,     // Converter powered
    output logic                      holding,     // Sampler in hold
    output logic                      fast_mode,   // Last end chose mode 1
    output logic                      conv_done,   // One-cycle end pulse
    output acrp_pkg::acrp_code_t      last_result  // Output data register
);
    import acrp_pkg::*;

    localparam int CW  = `ACRP_CODE_W;
    localparam int PW  = $clog2(PWRUP_CYC + 1);
    localparam int CNW = $clog2(CONV_CYC + 1);

    localparam logic [PW-1:0]  PULSE_LOAD = PW'(PWRUP_CYC - 1);
    localparam logic [CNW-1:0] CONV_LOAD  = CNW'(CONV_CYC - 1);
    localparam acrp_code_t     MSB_MASK   = acrp_code_t'(`ACRP_LSB_STEPS / 2);

    logic            start_q_r;
    logic [PW-1:0]   pulse_cnt_r;
    logic            pulse_r;
    logic            gated;
    logic            gated_q_r;
    logic            start_rise;
    logic            gate_fall;
    logic            conv_start;
    logic            conv_end;
    acrp_dev_state_t state_r;
    logic [CNW-1:0]  conv_cnt_r;
    acrp_code_t      sample_r;
    acrp_code_t      sar_r;
    acrp_code_t      mask_r;
    acrp_code_t      result_r;
    logic            busy_r;
    logic            hold_r;
    logic            pwr_r;
    logic            mode_hs_r;
    logic            done_r;
    logic            oe_r;
    acrp_code_t      bus_r;

    // One successive-approximation trial: keep the bit if not above input
    function automatic acrp_code_t sar_step(input acrp_code_t acc,
                                            input acrp_code_t bit_mask,
                                            input acrp_code_t level);
        acrp_code_t trial;
        trial = acc | bit_mask;
        if (trial <= level) begin
            sar_step = trial;
        end else begin
            sar_step = acc;
        end
    endfunction

    assign start_rise = link.convert_start_n & ~start_q_r;
    assign gated      = link.convert_start_n | pulse_r;
    assign gate_fall  = gated_q_r & ~gated;
    assign conv_start = gate_fall & pwr_r & (state_r == DEV_IDLE);
    assign conv_end   = (state_r == DEV_CONV) && (conv_cnt_r == '0);

    // Reset value low matches a start pin held low at power-up
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            start_q_r <= 1'b0;
            gated_q_r <= 1'b0;
        end else if (clk_en) begin
            start_q_r <= link.convert_start_n;
            gated_q_r <= gated;
        end
    end

    // Pulse stays high for exactly the power-up count after the rise
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pulse_r     <= 1'b0;
            pulse_cnt_r <= '0;
        end else if (clk_en) begin
            if (start_rise) begin
                pulse_r     <= 1'b1;
                pulse_cnt_r <= PULSE_LOAD;
            end else if (pulse_r) begin
                if (pulse_cnt_r == '0) begin
                    pulse_r <= 1'b0;
                end else begin
                    pulse_cnt_r <= pulse_cnt_r - 1'b1;
                end
            end
        end
    end

    // Power state: off after reset, on at any rising start edge
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pwr_r <= 1'b0;
        end else if (clk_en) begin
            if (start_rise) begin
                pwr_r <= 1'b1;
            end else if (conv_end) begin
                pwr_r <= link.convert_start_n;
            end
        end
    end

    // Conversion sequencer; one trial per cycle, then wait out the count
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_r    <= DEV_IDLE;
            conv_cnt_r <= '0;
            sample_r   <= '0;
            sar_r      <= '0;
            mask_r     <= '0;
            busy_r     <= 1'b0;
            hold_r     <= 1'b0;
        end else if (clk_en) begin
            unique case (state_r)
                DEV_IDLE: begin
                    if (conv_start) begin
                        state_r    <= DEV_CONV;
                        conv_cnt_r <= CONV_LOAD;
                        sample_r   <= analog_code;
                        sar_r      <= '0;
                        mask_r     <= MSB_MASK;
                        busy_r     <= 1'b1;
                        hold_r     <= 1'b1;
                    end
                end
                DEV_CONV: begin
                    if (mask_r != '0) begin
                        sar_r  <= sar_step(sar_r, mask_r, sample_r);
                        mask_r <= mask_r >> 1;
                    end
                    if (conv_cnt_r == '0) begin
                        state_r <= DEV_IDLE;
                        busy_r  <= 1'b0;
                        hold_r  <= 1'b0;
                    end else begin
                        conv_cnt_r <= conv_cnt_r - 1'b1;
                    end
                end
            endcase
        end
    end

    // Result register; cleared when busy rises so a stray read returns zero
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            result_r  <= '0;
            mode_hs_r <= 1'b0;
            done_r    <= 1'b0;
        end else if (clk_en) begin
            done_r <= conv_end;
            if (conv_start) begin
                result_r <= '0;
            end else if (conv_end) begin
                result_r  <= sar_r;
                mode_hs_r <= link.convert_start_n;
            end
        end
    end

    // Read port ignores the power state so a stored result stays readable
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            oe_r  <= 1'b0;
            bus_r <= '0;
        end else if (clk_en) begin
            oe_r <= ~link.cs_n & ~link.rd_n;
            if (~link.cs_n & ~link.rd_n) begin
                bus_r <= result_r;
            end else begin
                bus_r <= '0;
            end
        end
    end

    assign link.busy    = busy_r;
    assign link.data_oe = oe_r;
    assign link.data    = bus_r;
    assign powered      = pwr_r;
    assign holding      = hold_r;
    assign fast_mode    = mode_hs_r;
    assign conv_done    = done_r;
    assign last_result  = result_r;

endmodule

// ### logic/acrp_params.svh
`ifndef ACRP_PARAMS_SVH
`define ACRP_PARAMS_SVH

`define ACRP_CLK_NS      100
`define ACRP_CODE_W      8
`define ACRP_LSB_STEPS   256
`define ACRP_PWRUP_NS    1000
`define ACRP_PWRUP_CYC   ((`ACRP_PWRUP_NS + `ACRP_CLK_NS - 1) / `ACRP_CLK_NS)
`define ACRP_CONV_NS     4500
`define ACRP_CONV_CYC    (`ACRP_CONV_NS / `ACRP_CLK_NS)
`define ACRP_RD_GAP_NS   100
`define ACRP_RD_GAP_CYC  ((`ACRP_RD_GAP_NS + `ACRP_CLK_NS - 1) / `ACRP_CLK_NS)
`define ACRP_READ_CYC    2

`endif

// ### logic/acrp_pkg.sv
package acrp_pkg;
    typedef logic [7:0] acrp_code_t;

    typedef enum logic [0:0] {
        DEV_IDLE,
        DEV_CONV
    } acrp_dev_state_t;

    typedef enum logic [2:0] {
        H_IDLE,
        H_HIGH,
        H_LOW,
        H_CONV,
        H_READ,
        H_GAP
    } acrp_host_state_t;
endpackage

// ### logic/acrp_if.sv
`timescale 1ns/1ns
interface acrp_if;
    logic                 convert_start_n;
    logic                 cs_n;
    logic                 rd_n;
    logic                 busy;
    logic                 data_oe;
    acrp_pkg::acrp_code_t data;

    modport dev (
        input  convert_start_n,
        input  cs_n,
        input  rd_n,
        output busy,
        output data_oe,
        output data
    );

    modport host (
        output convert_start_n,
        output cs_n,
        output rd_n,
        input  busy,
        input  data_oe,
        input  data
    );
endinterface

// ### logic/acrp_host.sv
`timescale 1ns/1ns
`include "acrp_params.svh"

module acrp_host #(
    parameter int HI_CYC   = `ACRP_PWRUP_CYC,
    parameter int READ_CYC = `ACRP_READ_CYC,
    parameter int GAP_CYC  = `ACRP_RD_GAP_CYC
) (
    input  wire logic                 sys_clk,        // 10 MHz clock
    input  wire logic                 sys_rst,        // Sync reset, high
    input  wire logic                 clk_en,         // Low freezes state
    input  wire logic                 start_req,      // Request a sample
    input  wire logic                 power_down_sel, // Pick mode 2
    acrp_if.host                      link,           // Device pins
    output logic                      ready,          // Accepts start_req
    output logic                      result_valid,   // One-cycle pulse
    output acrp_pkg::acrp_code_t      result          // Last code read
);
    import acrp_pkg::*;

    localparam int CNTW = 8;

    acrp_host_state_t state_r;
    logic [CNTW-1:0]  cnt_r;
    logic             cvs_r;
    logic             cs_r;
    logic             rd_r;
    logic             pd_r;
    logic             ready_r;
    logic             valid_r;
    acrp_code_t       result_r;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_r  <= H_IDLE;
            cnt_r    <= '0;
            cvs_r    <= 1'b0;
            cs_r     <= 1'b1;
            rd_r     <= 1'b1;
            pd_r     <= 1'b0;
            ready_r  <= 1'b1;
            valid_r  <= 1'b0;
            result_r <= '0;
        end else if (clk_en) begin
            valid_r <= 1'b0;
            unique case (state_r)
                H_IDLE: begin
                    if (start_req) begin
                        // Above 100 kSPS the user should pick mode 1
                        pd_r    <= power_down_sel;
                        ready_r <= 1'b0;
                        if (!cvs_r) begin
                            cvs_r   <= 1'b1;
                            cnt_r   <= CNTW'(HI_CYC - 1);
                            state_r <= H_HIGH;
                        end else begin
                            cvs_r   <= 1'b0;
                            state_r <= H_LOW;
                        end
                    end
                end
                H_HIGH: begin
                    if (cnt_r == '0) begin
                        cvs_r   <= 1'b0;
                        state_r <= H_LOW;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                H_LOW: begin
                    if (link.busy) begin
                        cvs_r   <= ~pd_r;
                        state_r <= H_CONV;
                    end
                end
                H_CONV: begin
                    if (!link.busy) begin
                        cs_r    <= 1'b0;
                        rd_r    <= 1'b0;
                        cnt_r   <= CNTW'(READ_CYC - 1);
                        state_r <= H_READ;
                    end
                end
                H_READ: begin
                    if (cnt_r == '0) begin
                        result_r <= link.data;
                        valid_r  <= 1'b1;
                        cs_r     <= 1'b1;
                        rd_r     <= 1'b1;
                        cnt_r    <= CNTW'(GAP_CYC - 1);
                        state_r  <= H_GAP;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                H_GAP: begin
                    // No new start edge until the read has settled
                    if (cnt_r == '0) begin
                        ready_r <= 1'b1;
                        state_r <= H_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                default: begin
                    state_r <= H_IDLE;
                end
            endcase
        end
    end

    assign link.convert_start_n = cvs_r;
    assign link.cs_n            = cs_r;
    assign link.rd_n            = rd_r;
    assign ready                = ready_r;
    assign result_valid         = valid_r;
    assign result               = result_r;

endmodule

// ### testbench/acrp_link_asserts.sv
`timescale 1ns/1ns
module acrp_link_asserts
    import acrp_pkg::*;
#(
    parameter int PWRUP_CYC = 10,
    parameter int CONV_CYC  = 45
) (
    input wire logic                 sys_clk,         // Clock
    input wire logic                 sys_rst,         // Sync reset, high
    input wire logic                 convert_start_n, // Start pin
    input wire logic                 cs_n,            // Chip select
    input wire logic                 rd_n,            // Read strobe
    input wire logic                 busy,            // Conversion running
    input wire logic                 data_oe,         // Bus driven
    input wire acrp_pkg::acrp_code_t data             // Result byte
);
    logic [7:0] busy_cnt_r;
    logic [7:0] since_rise_r;
    logic [7:0] since_fall_r;
    logic       start_prev_r;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    always_ff @(posedge sys_clk) begin
        busy_cnt_r <= (sys_rst || !busy) ? 8'h00 : busy_cnt_r + 8'h01;
    end

    // Saturating ages, so a long idle never wraps into a false failure
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            since_rise_r <= 8'hff;
            since_fall_r <= 8'hff;
            start_prev_r <= 1'b0;
        end else begin
            start_prev_r <= convert_start_n;
            if (convert_start_n && !start_prev_r) begin
                since_rise_r <= 8'h00;
            end else if (since_rise_r != 8'hff) begin
                since_rise_r <= since_rise_r + 8'h01;
            end
            if (!convert_start_n && start_prev_r) begin
                since_fall_r <= 8'h00;
            end else if (since_fall_r != 8'hff) begin
                since_fall_r <= since_fall_r + 8'h01;
            end
        end
    end

    property p_busy_len;
        $fell(busy) |-> busy_cnt_r == CONV_CYC;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("busy width wrong");
    property p_pwrup_gap;
        $rose(busy) |-> since_rise_r >= PWRUP_CYC;
    endproperty
    a_pwrup_gap: assert property (p_pwrup_gap)
        else $error("conversion inside power-up pulse");
    property p_start_low;
        $rose(busy) |-> !$past(convert_start_n);
    endproperty
    a_start_low: assert property (p_start_low)
        else $error("conversion while start high");
    property p_oe_cause;
        $rose(data_oe) |-> !$past(cs_n) && !$past(rd_n);
    endproperty
    a_oe_cause: assert property (p_oe_cause)
        else $error("bus driven without strobes");
    property p_oe_follow;
        (!cs_n && !rd_n) |=> data_oe;
    endproperty
    a_oe_follow: assert property (p_oe_follow)
        else $error("read not answered");
    property p_release;
        (cs_n || rd_n) |=> !data_oe && data == 8'h00;
    endproperty
    a_release: assert property (p_release)
        else $error("bus not released");
    property p_busy_clear;
        (busy && $past(busy)) |-> !data_oe || data == 8'h00;
    endproperty
    a_busy_clear: assert property (p_busy_clear)
        else $error("read port not reset in conversion");
    property p_no_read_busy;
        busy |-> cs_n && rd_n;
    endproperty
    a_no_read_busy: assert property (p_no_read_busy)
        else $error("read during conversion");
    property p_read_gap;
        $fell(convert_start_n) |-> $past(cs_n) && $past(rd_n);
    endproperty
    a_read_gap: assert property (p_read_gap)
        else $error("start too soon after read");
    property p_fall_space;
        $fell(convert_start_n) |-> since_fall_r >= CONV_CYC + 2;
    endproperty
    a_fall_space: assert property (p_fall_space)
        else $error("starts too close");
    property p_reset_low;
        $fell(sys_rst) |-> !convert_start_n;
    endproperty
    a_reset_low: assert property (p_reset_low)
        else $error("start high after reset");

    c_mode1: cover property ($fell(busy) && convert_start_n);
    c_mode2: cover property ($fell(busy) && !convert_start_n);
    c_read: cover property ($rose(data_oe));
endmodule

// ### testbench/adc_convert_start_and_read_port_test.sv
`timescale 1ns/1ns
`include "acrp_params.svh"
module adc_convert_start_and_read_port_test;
    import acrp_pkg::*;
    localparam int PU = `ACRP_PWRUP_CYC;
    localparam int CV = `ACRP_CONV_CYC;
    logic       sys_clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic       start_req = 1'b0;
    logic       pd_sel = 1'b0;
    acrp_code_t code = 8'h00;
    logic       powered, holding, fast_mode, conv_done, ready, res_valid;
    acrp_code_t last_result, result;
    int         fail_count = 0;
    int         checked = 0;

    acrp_if lnk ();
    always #50 sys_clk = ~sys_clk;

    acrp_device acrp_device_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .clk_en(1'b1), .analog_code(code), .link(lnk), .powered(powered),
        .holding(holding), .fast_mode(fast_mode), .conv_done(conv_done),
        .last_result(last_result));
    acrp_host acrp_host_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .clk_en(1'b1), .start_req(start_req), .power_down_sel(pd_sel),
        .link(lnk), .ready(ready), .result_valid(res_valid), .result(result));
    acrp_link_asserts #(.PWRUP_CYC(PU), .CONV_CYC(CV)) acrp_link_asserts_i (
        .sys_clk(sys_clk), .sys_rst(sys_rst),
        .convert_start_n(lnk.convert_start_n), .cs_n(lnk.cs_n),
        .rd_n(lnk.rd_n), .busy(lnk.busy), .data_oe(lnk.data_oe),
        .data(lnk.data));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask

    task automatic stop_test();
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One full sample through the host; cold means the converter starts off
    task automatic conv(input logic sel, input acrp_code_t c,
                        input logic cold);
        int n;
        n = 0;
        @(posedge sys_clk) code <= c;
        pd_sel <= sel;
        start_req <= 1'b1;
        @(posedge sys_clk) start_req <= 1'b0;
        #1;
        while (lnk.busy !== 1'b1 && n < 300) begin
            tick();
            n++;
        end
        // Cold start waits out the host pulse, then the gated fall
        chk(n, cold ? PU + 2 : 1);
        n = 0;
        while (lnk.busy === 1'b1 && n < 300) begin
            chk({holding, powered}, 2'h3);
            chk(last_result, 8'h00);
            tick();
            n++;
        end
        chk(n, CV);
        chk(last_result, c);
        chk(holding, 1'b0);
        chk(conv_done, 1'b1);
        tick();
        chk(conv_done, 1'b0);
        chk({fast_mode, powered}, {~sel, ~sel});
        n = 0;
        while (res_valid !== 1'b1 && n < 50) begin
            if (lnk.data_oe === 1'b1) chk(lnk.data, c);
            tick();
            n++;
        end
        chk({result, powered}, {c, ~sel});
        while (ready !== 1'b1 && n < 60) begin
            tick();
            n++;
        end
        chk(n < 60, 1'b1);
        chk({lnk.data_oe, lnk.data}, 9'h000);
    endtask

    task automatic t_reset();
        chk({lnk.busy, lnk.data_oe}, 2'h0);
        chk({powered, lnk.convert_start_n}, 2'h0);
        chk(ready, 1'b1);
    endtask

    task automatic t_cold_pd();
        conv(1'b1, 8'ha5, 1'b1);
    endtask

    task automatic t_to_fast();
        conv(1'b0, 8'h5a, 1'b1);
    endtask

    task automatic t_fast_b2b();
        conv(1'b0, 8'hff, 1'b0);
        conv(1'b0, 8'h00, 1'b0);
    endtask

    task automatic t_fast_to_pd();
        conv(1'b1, 8'h01, 1'b0);
        conv(1'b1, 8'h80, 1'b1);
    endtask

    initial begin
        #1000000;
        fail_count++;
        stop_test();
    end

    initial begin
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        #1;
        t_reset();
        t_cold_pd();
        t_to_fast();
        t_fast_b2b();
        t_fast_to_pd();
        stop_test();
    end
endmodule
